// ### verilog/pmd_consts.svh
// Purpose: Named constants shared by both ends of the data port.
// Assumes: A 50 MHz system clock on both ends.
// Notes:   Definitions only; included by bare name.
`ifndef PMD_CONSTS_SVH
`define PMD_CONSTS_SVH

`define PMD_CLK_HZ        50000000
`define PMD_LCLK100_HZ    25000000
`define PMD_LCLK10_HZ     2500000
`define PMD_HALF100_CYC   (`PMD_CLK_HZ / (2 * `PMD_LCLK100_HZ))
`define PMD_HALF10_CYC    (`PMD_CLK_HZ / (2 * `PMD_LCLK10_HZ))
`define PMD_BLINK10_HZ    10
`define PMD_BLINK20_HZ    20
`define PMD_BLINK10_CYC   (`PMD_CLK_HZ / `PMD_BLINK10_HZ)
`define PMD_BLINK20_CYC   (`PMD_CLK_HZ / `PMD_BLINK20_HZ)
`define PMD_DIV_W         4
`define PMD_BLINK_W       23
`define PMD_SYM_INVALID   5'h04
`define PMD_MASK_MII      4'hf
`define PMD_MASK_RMII     4'h3
`define PMD_MASK_SMII     4'h1
`define PMD_TXV_W         6

`endif

// ### verilog/pmd_pkg.sv
// Purpose: Types used by the PHY end of the data port and the testbench.
// Assumes: Nothing beyond the constants header.
// Notes:   Holds types only.
package pmd_pkg;
	typedef enum logic [1:0] {
		PMD_MODE_MII  = 2'b00,
		PMD_MODE_RMII = 2'b01,
		PMD_MODE_SMII = 2'b10
	} pmd_ifmode_t;
endpackage : pmd_pkg

// ### verilog/pmd_mii_if.sv
// Purpose: Media independent data port wires between PHY and MAC.
// Assumes: The PHY end drives both link clocks.
// Notes:   No clocking block; each end samples the clocks itself.
`timescale 1ns/1ps
interface pmd_mii_if;
	logic [3:0] txd;
	logic       tx_en;
	logic       tx_er;
	logic       tx_clk;
	logic [3:0] rxd;
	logic       rx_dv;
	logic       rx_er;
	logic       rx_clk;
	logic       col;
	logic       crs;

	modport phy (
		input  txd, tx_en, tx_er,
		output tx_clk, rxd, rx_dv, rx_er, rx_clk, col, crs
	);
	modport mac (
		output txd, tx_en, tx_er,
		input  tx_clk, rxd, rx_dv, rx_er, rx_clk, col, crs
	);
endinterface : pmd_mii_if

// ### verilog/pmd_mac_end.sv
// Purpose: MAC end of the data port: sends nibbles, collects received ones.
// Assumes: Link clocks come from the PHY and are sampled on I_CLK.
// Notes:   Link edges are only seen when each half period spans
//          several I_CLK cycles, so 25 MHz link clocks cannot be tracked.
`include "pmd_consts.svh"
`timescale 1ns/1ps
module pmd_mac_end (
	input  wire logic       I_CLK,         // System clock.
	input  wire logic       I_RSTN,        // Asynchronous reset, low.
	pmd_mii_if.mac          mii,           // Link to the PHY.
	input  wire logic       I_SYMBOL_MODE, // Five bit symbol mode.
	input  wire logic [3:0] I_TX_DATA,     // Nibble to send.
	input  wire logic       I_TX_ERR,      // Error flag or fifth bit.
	input  wire logic       I_TX_VALID,    // Nibble waiting.
	output logic            O_TX_TAKEN,    // Nibble sent, pulse.
	output logic [3:0]      O_RX_DATA,     // Received nibble.
	output logic            O_RX_ERR,      // Receive error or bit 4.
	output logic            O_RX_VALID,    // Data valid at capture.
	output logic            O_RX_STROBE,   // New receive sample, pulse.
	output logic            O_COL,         // Filtered collision.
	output logic            O_CRS          // Filtered carrier sense.
);
	localparam int SW = 10;

	logic [SW-1:0] s1_reg, s2_reg, s3_reg, f_reg, f_next;
	logic [SW-1:0] pins;
	logic          txclk_old_reg, rxclk_old_reg;
	logic          tx_rise, rx_rise;
	logic [3:0]    txd_reg;
	logic          txen_reg, txer_reg, taken_reg;
	logic [3:0]    rxd_reg;
	logic          rxer_reg, rxdv_reg, rxstb_reg;

	assign pins = {mii.crs, mii.col, mii.tx_clk, mii.rx_clk,
		mii.rx_er, mii.rx_dv, mii.rxd};
	// A bit moves only once the second and third stages agree.
	assign f_next = (~(s2_reg ^ s3_reg) & s3_reg) |
		((s2_reg ^ s3_reg) & f_reg);
	assign tx_rise = f_reg[7] & ~txclk_old_reg;
	assign rx_rise = f_reg[6] & ~rxclk_old_reg;

	always_ff @(posedge I_CLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			s1_reg        <= '0;
			s2_reg        <= '0;
			s3_reg        <= '0;
			f_reg         <= '0;
			txclk_old_reg <= 1'b0;
			rxclk_old_reg <= 1'b0;
		end else begin
			s1_reg        <= pins;
			s2_reg        <= s1_reg;
			s3_reg        <= s2_reg;
			f_reg         <= f_next;
			txclk_old_reg <= f_reg[7];
			rxclk_old_reg <= f_reg[6];
		end
	end

	// New values go out just after the PHY's sampling edge.
	always_ff @(posedge I_CLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			txd_reg   <= 4'h0;
			txen_reg  <= 1'b0;
			txer_reg  <= 1'b0;
			taken_reg <= 1'b0;
		end else begin
			taken_reg <= tx_rise & I_TX_VALID;
			if (tx_rise) begin
				txd_reg  <= I_TX_VALID ? I_TX_DATA : 4'h0;
				txen_reg <= I_TX_VALID;
				// Error flag, or the fifth symbol bit.
				txer_reg <= (I_TX_VALID | I_SYMBOL_MODE) & I_TX_ERR;
			end
		end
	end

	// Receive lines are settled by the rising edge of rx_clk.
	always_ff @(posedge I_CLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			rxd_reg   <= 4'h0;
			rxer_reg  <= 1'b0;
			rxdv_reg  <= 1'b0;
			rxstb_reg <= 1'b0;
		end else begin
			rxstb_reg <= rx_rise;
			if (rx_rise) begin
				rxd_reg  <= f_reg[3:0];
				rxdv_reg <= f_reg[4];
				rxer_reg <= f_reg[5];
			end
		end
	end

	assign mii.txd     = txd_reg;
	assign mii.tx_en   = txen_reg;
	assign mii.tx_er   = txer_reg;
	assign O_TX_TAKEN  = taken_reg;
	assign O_RX_DATA   = rxd_reg;
	assign O_RX_ERR    = rxer_reg;
	assign O_RX_VALID  = rxdv_reg;
	assign O_RX_STROBE = rxstb_reg;
	assign O_COL       = f_reg[8];
	assign O_CRS       = f_reg[9];
endmodule : pmd_mac_end

// ### verilog/pmd_phy_end.sv
// Purpose: PHY end of the data port with its five status indicators.
// Assumes: I_CLK is the 50 MHz system clock; line side is same domain.
// Notes:   Link clocks are divided from I_CLK and driven as outputs.
`include "pmd_consts.svh"
`timescale 1ns/1ps
module pmd_phy_end #(
	parameter logic [`PMD_BLINK_W-1:0] P_BLINK10_CYC =
		`PMD_BLINK_W'(`PMD_BLINK10_CYC),
	parameter logic [`PMD_BLINK_W-1:0] P_BLINK20_CYC =
		`PMD_BLINK_W'(`PMD_BLINK20_CYC)
) (
	input  wire logic        I_CLK,                // System clock.
	input  wire logic        I_RSTN,               // Async reset, low.
	pmd_mii_if.phy           mii,                  // Link to the MAC.
	input  wire logic        I_SPEED_100,          // 1: 100, 0: 10 Mbps.
	input  wire logic        I_DUPLEX_CONTROL_BIT, // 1: full duplex.
	input  pmd_pkg::pmd_ifmode_t I_IF_MODE,        // Interface mode.
	input  wire logic        I_SYMBOL_MODE,        // Five bit symbols.
	input  wire logic        I_LINK_GOOD,          // Good link seen.
	input  wire logic [4:0]  I_LINE_RX_SYM,        // Decoded line data.
	input  wire logic        I_LINE_RX_VALID,      // Line data valid.
	input  wire logic        I_LINE_RX_INVALID,    // Bad line symbol.
	input  wire logic        I_LINE_RX_ACTIVE,     // Receive non-idle.
	input  wire logic        I_LINE_COL,           // Collision seen.
	output logic [4:0]       O_LINE_TX_SYM,        // Symbol to the line.
	output logic             O_LINE_TX_EN,         // Enable or sync.
	output logic             O_LINE_TX_STROBE,     // New symbol, pulse.
	output logic             O_LED_10,             // 10 Mbps indicator.
	output logic             O_LED_100,            // 100 Mbps indicator.
	output logic             O_LED_ACT,            // Activity indicator.
	output logic             O_LED_LINK,           // Link indicator.
	output logic             O_LED_DUPCOL          // Duplex/collision.
);
	localparam logic [`PMD_DIV_W-1:0] HALF100 =
		`PMD_DIV_W'(`PMD_HALF100_CYC - 1);
	localparam logic [`PMD_DIV_W-1:0] HALF10 =
		`PMD_DIV_W'(`PMD_HALF10_CYC - 1);

	function automatic logic [3:0] mode_mask(
		input pmd_pkg::pmd_ifmode_t m
	);
		logic [3:0] r;
		r = `PMD_MASK_MII;
		if (m == pmd_pkg::PMD_MODE_RMII)
			r = `PMD_MASK_RMII;
		else if (m == pmd_pkg::PMD_MODE_SMII)
			r = `PMD_MASK_SMII;
		return r;
	endfunction : mode_mask

	// A blink period restarts from zero whenever its trigger is absent.
	function automatic logic [`PMD_BLINK_W-1:0] blink_step(
		input logic [`PMD_BLINK_W-1:0] c,
		input logic                    run,
		input logic [`PMD_BLINK_W-1:0] period
	);
		logic [`PMD_BLINK_W-1:0] r;
		r = '0;
		if (run && c != period - `PMD_BLINK_W'(1))
			r = c + `PMD_BLINK_W'(1);
		return r;
	endfunction : blink_step

	logic [`PMD_DIV_W-1:0]   div_reg, div_next;
	logic                    lclk_reg;
	logic                    wrap, rise, fall;
	logic [`PMD_TXV_W-1:0]   s1_reg, s2_reg, s3_reg, f_reg, f_next;
	logic [3:0]              tx_mask;
	logic [4:0]              tx_sym;
	logic [4:0]              txsym_reg;
	logic                    txen_reg, txstb_reg;
	logic [3:0]              rxd_reg;
	logic                    rxdv_reg, rxer_reg;
	logic                    col_reg, crs_reg;
	logic                    col_on, crs_next;
	logic [`PMD_BLINK_W-1:0] act_cnt_reg, link_cnt_reg, col_cnt_reg;
	logic                    act_run, link_run;
	logic                    led10_reg, led100_reg, ledact_reg;
	logic                    ledlink_reg, leddup_reg;

	// One divider makes both link clocks, so rx_clk runs always.
	assign wrap = div_reg == (I_SPEED_100 ? HALF100 : HALF10);
	assign div_next = wrap ? '0 : div_reg + `PMD_DIV_W'(1);
	assign rise = wrap & ~lclk_reg;
	assign fall = wrap & lclk_reg;

	always_ff @(posedge I_CLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			div_reg  <= '0;
			lclk_reg <= 1'b0;
		end else begin
			div_reg  <= div_next;
			lclk_reg <= lclk_reg ^ wrap;
		end
	end

	// Transmit pins cross from the MAC's domain through three stages.
	assign f_next = (~(s2_reg ^ s3_reg) & s3_reg) |
		((s2_reg ^ s3_reg) & f_reg);

	always_ff @(posedge I_CLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			s1_reg <= '0;
			s2_reg <= '0;
			s3_reg <= '0;
			f_reg  <= '0;
		end else begin
			s1_reg <= {mii.tx_er, mii.tx_en, mii.txd};
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			f_reg  <= f_next;
		end
	end

	assign tx_mask = mode_mask(I_IF_MODE);
	// Bit 4 is tx_er only in symbol mode; a flagged error at 100 Mbps
	// replaces the data so the far end sees a coding violation.
	assign tx_sym = I_SYMBOL_MODE ? {f_reg[5], f_reg[3:0] & tx_mask} :
		(I_SPEED_100 && f_reg[5] && f_reg[4]) ? `PMD_SYM_INVALID :
		{1'b0, f_reg[3:0] & tx_mask};

	// The MAC's lines are sampled as the link clock rises.
	always_ff @(posedge I_CLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			txsym_reg <= 5'h00;
			txen_reg  <= 1'b0;
			txstb_reg <= 1'b0;
		end else begin
			txstb_reg <= rise;
			if (rise) begin
				txsym_reg <= tx_sym;
				txen_reg  <= f_reg[4];
			end
		end
	end

	// Receive lines change as the link clock falls, half a period
	// before the MAC samples them.
	always_ff @(posedge I_CLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			rxd_reg  <= 4'h0;
			rxdv_reg <= 1'b0;
			rxer_reg <= 1'b0;
		end else if (fall) begin
			rxd_reg  <= I_LINE_RX_SYM[3:0] & tx_mask;
			rxer_reg <= I_SYMBOL_MODE ? I_LINE_RX_SYM[4] :
				I_LINE_RX_INVALID;
			rxdv_reg <= (I_IF_MODE == pmd_pkg::PMD_MODE_RMII) ?
				(I_LINE_RX_VALID | I_LINE_RX_ACTIVE) :
				I_LINE_RX_VALID;
		end
	end

	// Collision and carrier are not tied to a link clock edge; one
	// register stage keeps the outputs glitch free.
	assign col_on = I_LINE_COL & ~I_DUPLEX_CONTROL_BIT;
	assign crs_next = I_LINE_RX_ACTIVE |
		(~I_DUPLEX_CONTROL_BIT & txen_reg);

	always_ff @(posedge I_CLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			col_reg <= 1'b0;
			crs_reg <= 1'b0;
		end else begin
			col_reg <= col_on;
			crs_reg <= crs_next;
		end
	end

	assign act_run  = I_LINE_RX_ACTIVE & ~I_LINE_COL;
	assign link_run = I_LINE_RX_ACTIVE | txen_reg;

	always_ff @(posedge I_CLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			act_cnt_reg  <= '0;
			link_cnt_reg <= '0;
			col_cnt_reg  <= '0;
		end else begin
			act_cnt_reg  <= blink_step(act_cnt_reg, act_run,
				P_BLINK10_CYC);
			link_cnt_reg <= blink_step(link_cnt_reg, link_run,
				P_BLINK10_CYC);
			col_cnt_reg  <= blink_step(col_cnt_reg, col_on,
				P_BLINK20_CYC);
		end
	end

	// Each blinking indicator is lit in the first half of its period.
	always_ff @(posedge I_CLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			led10_reg   <= 1'b0;
			led100_reg  <= 1'b0;
			ledact_reg  <= 1'b0;
			ledlink_reg <= 1'b0;
			leddup_reg  <= 1'b0;
		end else begin
			led10_reg   <= ~I_SPEED_100;
			led100_reg  <= I_SPEED_100;
			ledact_reg  <= act_run &
				(act_cnt_reg < (P_BLINK10_CYC >> 1));
			ledlink_reg <= I_LINK_GOOD & (~link_run |
				(link_cnt_reg < (P_BLINK10_CYC >> 1)));
			leddup_reg  <= I_DUPLEX_CONTROL_BIT | (col_on &
				(col_cnt_reg < (P_BLINK20_CYC >> 1)));
		end
	end

	assign mii.tx_clk       = lclk_reg;
	assign mii.rx_clk       = lclk_reg;
	assign mii.rxd          = rxd_reg;
	assign mii.rx_dv        = rxdv_reg;
	assign mii.rx_er        = rxer_reg;
	assign mii.col          = col_reg;
	assign mii.crs          = crs_reg;
	assign O_LINE_TX_SYM    = txsym_reg;
	assign O_LINE_TX_EN     = txen_reg;
	assign O_LINE_TX_STROBE = txstb_reg;
	assign O_LED_10         = led10_reg;
	assign O_LED_100        = led100_reg;
	assign O_LED_ACT        = ledact_reg;
	assign O_LED_LINK       = ledlink_reg;
	assign O_LED_DUPCOL     = leddup_reg;
endmodule : pmd_phy_end

// ### tb/pmd_link_checker.sv
// Purpose: Concurrent checks on the wires between the two ends.
// Assumes: Mode and duplex change only while reset is held.
// Notes:   Speed may rise to 100 Mbps mid-run, so slow checks stop then.
`timescale 1ns/1ps
module pmd_link_checker (
	input  wire logic           I_CLK,                // Clock.
	input  wire logic           I_RSTN,               // Reset, low.
	input  wire logic           I_SPEED_100,          // Speed.
	input  wire logic           I_DUPLEX_CONTROL_BIT, // Duplex.
	input  pmd_pkg::pmd_ifmode_t I_IF_MODE,           // Mode.
	input  wire logic [3:0]     txd,                  // Tx data.
	input  wire logic           tx_en,                // Tx enable.
	input  wire logic           tx_er,                // Tx error.
	input  wire logic           tx_clk,               // Tx clock.
	input  wire logic [3:0]     rxd,                  // Rx data.
	input  wire logic           rx_dv,                // Rx valid.
	input  wire logic           rx_er,                // Rx error.
	input  wire logic           rx_clk,               // Rx clock.
	input  wire logic           col                   // Collision.
);
	default clocking cb @(posedge I_CLK);
	endclocking
	default disable iff (!I_RSTN);

	a_clk_pair: assert property (tx_clk == rx_clk)
		else $error("link clocks differ");
	a_high_slow: assert property (disable iff (!I_RSTN || I_SPEED_100)
		$rose(tx_clk) |=> tx_clk [*8] ##1 tx_clk ##1 !tx_clk)
		else $error("slow clock high phase wrong");
	a_low_slow: assert property (disable iff (!I_RSTN || I_SPEED_100)
		$fell(tx_clk) |=> !tx_clk [*8] ##1 !tx_clk ##1 tx_clk)
		else $error("slow clock low phase wrong");
	// A deep look back lets the divider settle after a speed change.
	a_fast_toggle: assert property (
		I_SPEED_100 && $past(I_SPEED_100, 20) && tx_clk |=> !tx_clk)
		else $error("fast clock not toggling");
	a_rx_hold: assert property (
		rx_clk && $past(rx_clk) |-> $stable({rxd, rx_dv, rx_er}))
		else $error("receive pins moved while clock high");
	a_tx_hold: assert property (
		!tx_clk && !$past(tx_clk) |-> $stable({txd, tx_en, tx_er}))
		else $error("transmit pins moved while clock low");
	a_col_full: assert property ($past(I_DUPLEX_CONTROL_BIT) |-> !col)
		else $error("collision in full duplex");
	a_mask_rmii: assert property (
		I_IF_MODE == pmd_pkg::PMD_MODE_RMII |-> rxd[3:2] == 2'h0)
		else $error("unused receive bits driven");
	a_mask_smii: assert property (
		I_IF_MODE == pmd_pkg::PMD_MODE_SMII |-> rxd[3:1] == 3'h0)
		else $error("unused receive bits driven");
endmodule : pmd_link_checker

// ### tb/tb.sv
// Purpose: Both ends joined back to back, driven from their user sides.
// Assumes: Blink periods shortened to 20 and 10 cycles.
// Notes:   Link transfers run at 10 Mbps, which the MAC end can follow; one transmit case then samples at 100 Mbps.
`include "pmd_consts.svh"
`timescale 1ns/1ps
module tb;
	logic                 clk   = 1'h0;
	logic                 rstn  = 1'h0;
	logic                 spd   = 1'h0;
	logic                 dup   = 1'h0;
	logic                 symm  = 1'h0;
	logic                 lgood = 1'h0;
	pmd_pkg::pmd_ifmode_t mode  = pmd_pkg::PMD_MODE_MII;
	logic [4:0]           lsym  = 5'h00;
	logic                 lval  = 1'h0;
	logic                 linv  = 1'h0;
	logic                 lact  = 1'h0;
	logic                 lcol  = 1'h0;
	logic [3:0]           txd   = 4'h0;
	logic                 txe   = 1'h0;
	logic                 txv   = 1'h0;
	logic [4:0]           tsym;
	logic [4:0]           leds;
	logic [3:0]           rdat;
	logic                 ten, tstb, taken, rerr, rval, rstb, mcol, mcrs;
	int                   miscompares = 0;
	int                   check_count = 0;
	int                   cyc = 0;
	int                   n;
	pmd_mii_if mii ();

	pmd_phy_end #(.P_BLINK10_CYC(23'h14), .P_BLINK20_CYC(23'ha)) i_pmd_phy_end (
		.I_CLK(clk), .I_RSTN(rstn), .mii(mii), .I_SPEED_100(spd),
		.I_DUPLEX_CONTROL_BIT(dup), .I_IF_MODE(mode), .I_SYMBOL_MODE(symm),
		.I_LINK_GOOD(lgood), .I_LINE_RX_SYM(lsym), .I_LINE_RX_VALID(lval),
		.I_LINE_RX_INVALID(linv), .I_LINE_RX_ACTIVE(lact), .I_LINE_COL(lcol),
		.O_LINE_TX_SYM(tsym), .O_LINE_TX_EN(ten), .O_LINE_TX_STROBE(tstb),
		.O_LED_10(leds[4]), .O_LED_100(leds[3]), .O_LED_ACT(leds[2]),
		.O_LED_LINK(leds[1]), .O_LED_DUPCOL(leds[0]));
	pmd_mac_end i_pmd_mac_end (
		.I_CLK(clk), .I_RSTN(rstn), .mii(mii), .I_SYMBOL_MODE(symm),
		.I_TX_DATA(txd), .I_TX_ERR(txe), .I_TX_VALID(txv), .O_TX_TAKEN(taken),
		.O_RX_DATA(rdat), .O_RX_ERR(rerr), .O_RX_VALID(rval),
		.O_RX_STROBE(rstb), .O_COL(mcol), .O_CRS(mcrs));
	pmd_link_checker i_pmd_link_checker (
		.I_CLK(clk), .I_RSTN(rstn), .I_SPEED_100(spd),
		.I_DUPLEX_CONTROL_BIT(dup), .I_IF_MODE(mode), .txd(mii.txd),
		.tx_en(mii.tx_en), .tx_er(mii.tx_er), .tx_clk(mii.tx_clk),
		.rxd(mii.rxd), .rx_dv(mii.rx_dv), .rx_er(mii.rx_er),
		.rx_clk(mii.rx_clk), .col(mii.col));

	initial forever #10 clk = ~clk;

	task final_report;
		if (miscompares == 0 && check_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : final_report

	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			miscompares = miscompares + 1;
			final_report();
		end
	end

	task check(input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("wrong value at %0t: %h expected %h", $time, seen, exp);
		end
	endtask : check

	// Mode and duplex move only under reset, as the checker expects.
	task do_reset(input logic s, input logic d, input pmd_pkg::pmd_ifmode_t m,
		input logic y);
		@(posedge clk);
		rstn <= 1'h0;
		spd  <= s;
		dup  <= d;
		mode <= m;
		symm <= y;
		{lgood, lval, linv, lact, lcol, txv, txe} <= 7'h0;
		repeat (4) @(posedge clk);
		rstn <= 1'h1;
		@(posedge clk);
	endtask : do_reset

	task automatic wait_hi(ref logic s);
		int i;
		i = 0;
		do @(negedge clk);
		while (s !== 1'h1 && ++i < 400);
	endtask : wait_hi

	task count_on(input int k, output int c);
		c = 0;
		repeat (4) @(negedge clk);
		repeat (40) begin
			@(negedge clk);
			c += leds[k];
		end
	endtask : count_on

	task tx_case(input pmd_pkg::pmd_ifmode_t m, input logic y, input logic up,
		input logic [3:0] d, input logic e, input logic [4:0] exp);
		do_reset(1'h0, 1'h0, m, y);
		{txd, txe, txv} <= {d, e, 1'h1};
		wait_hi(taken);
		@(posedge clk);
		txv <= up;
		spd <= up;
		repeat (up ? 3 : 1) wait_hi(tstb);
		check({2'h0, ten, tsym}, {2'h0, 1'h1, exp});
		if (!up) begin
			wait_hi(tstb);
			check({7'h0, ten}, 8'h00);
		end
	endtask : tx_case

	task rx_case(input pmd_pkg::pmd_ifmode_t m, input logic y,
		input logic [4:0] s, input logic [2:0] f, input logic [7:0] exp);
		do_reset(1'h0, 1'h0, m, y);
		lsym <= s;
		{lval, linv, lact} <= f;
		repeat (3) wait_hi(rstb);
		check({2'h0, rval, rerr, rdat}, exp);
	endtask : rx_case

	task col_crs(input logic d);
		do_reset(1'h0, d, pmd_pkg::PMD_MODE_MII, 1'h0);
		{lcol, txv} <= 2'h3;
		wait_hi(taken);
		repeat (30) @(negedge clk);
		check({4'h0, mii.col, mii.crs, mcol, mcrs}, {4'h0, {4{~d}}});
		count_on(0, n);
		check(8'(n), d ? 8'h28 : 8'h14);
	endtask : col_crs

	task leds_case(input logic s);
		do_reset(s, 1'h1, pmd_pkg::PMD_MODE_MII, 1'h0);
		lgood <= 1'h1;
		count_on(1, n);
		check({6'h0, leds[4:3]}, {6'h0, ~s, s});
		check(8'(n), 8'h28);
		@(posedge clk);
		lact <= 1'h1;
		count_on(2, n);
		check(8'(n), 8'h14);
		count_on(1, n);
		check(8'(n), 8'h14);
	endtask : leds_case

	initial begin
		tx_case(pmd_pkg::PMD_MODE_MII, 1'h0, 1'h0, 4'ha, 1'h0, 5'h0a);
		tx_case(pmd_pkg::PMD_MODE_RMII, 1'h0, 1'h0, 4'ha, 1'h0, 5'h02);
		tx_case(pmd_pkg::PMD_MODE_SMII, 1'h0, 1'h0, 4'hb, 1'h0, 5'h01);
		tx_case(pmd_pkg::PMD_MODE_MII, 1'h0, 1'h0, 4'h6, 1'h1, 5'h06);
		tx_case(pmd_pkg::PMD_MODE_MII, 1'h1, 1'h0, 4'h6, 1'h1, 5'h16);
		tx_case(pmd_pkg::PMD_MODE_MII, 1'h0, 1'h1, 4'h6, 1'h1, `PMD_SYM_INVALID);
		rx_case(pmd_pkg::PMD_MODE_MII, 1'h0, 5'h1b, 3'h6, 8'h3b);
		rx_case(pmd_pkg::PMD_MODE_MII, 1'h1, 5'h15, 3'h4, 8'h35);
		rx_case(pmd_pkg::PMD_MODE_RMII, 1'h0, 5'h0e, 3'h1, 8'h22);
		rx_case(pmd_pkg::PMD_MODE_SMII, 1'h0, 5'h0f, 3'h4, 8'h21);
		col_crs(1'h0);
		col_crs(1'h1);
		leds_case(1'h0);
		leds_case(1'h1);
		final_report();
	end
endmodule : tb
